// >>> hdl/smc_pkg.sv
package smc_pkg;

	// Clock rate in MHz.
	localparam int unsigned CLK_MHZ = 250;

	// Timing figures in their own units.
	localparam int unsigned RESET_MIN_US = 1000;
	localparam int unsigned UV_HOLD_MS = 100;
	localparam int unsigned NREQ_TO_MS = 75;
	localparam int unsigned WAKE_FILT_US = 30;
	localparam int unsigned CYCLIC_PERIOD_MS = 20;
	localparam int unsigned CYCLIC_ON_US = 200;
	localparam int unsigned US_PER_MS = 1000;

	// Watchdog periods in ms, disable window plus enable window.
	localparam logic [7:0] WD_MS_TAB [8] = '{8'h05, 8'h0a, 8'h14, 8'h21,
		8'h32, 8'h4b, 8'h64, 8'hc8};

	// Command frame layout.
	localparam int unsigned CMD_W = 16;
	localparam int unsigned CMD_ADDR_HI = 15;
	localparam int unsigned CMD_ADDR_LO = 13;
	localparam int unsigned CNT_W = 4;
	localparam logic [3:0] CNT_LAST = 4'hf;

	// Command addresses.
	localparam logic [2:0] ADDR_TIMING = 3'h0;
	localparam logic [2:0] ADDR_MODE = 3'h1;
	localparam logic [2:0] ADDR_CAN = 3'h2;
	localparam logic [2:0] ADDR_WDOG = 3'h3;
	localparam logic [2:0] ADDR_WAKE_CLR = 3'h4;

	// Data field positions.
	localparam int unsigned WD_SEL_HI = 2;
	localparam int unsigned MODE_REQ_HI = 2;
	localparam int unsigned MODE_BATT_BIT = 3;
	localparam int unsigned MODE_CYCLIC_BIT = 4;
	localparam int unsigned CAN_MODE_HI = 1;
	localparam int unsigned WAKE_CLR_HI = 1;

	// Mode requests.
	localparam logic [2:0] REQ_NORMAL = 3'h0;
	localparam logic [2:0] REQ_STANDBY = 3'h1;
	localparam logic [2:0] REQ_SLEEP = 3'h2;
	localparam logic [2:0] REQ_EMERG = 3'h3;

	// Transceiver modes.
	localparam logic [1:0] CAN_STBY = 2'h0;
	localparam logic [1:0] CAN_FD = 2'h1;
	localparam logic [1:0] CAN_LO = 2'h2;

	// Synchronised pin indices.
	localparam int unsigned PIN_MAIN_UV = 0;
	localparam int unsigned PIN_AUX_UV = 1;
	localparam int unsigned PIN_CANH = 2;
	localparam int unsigned PIN_CANL = 3;
	localparam int unsigned PIN_RST = 4;
	localparam int unsigned PIN_BAT_LOSS = 5;
	localparam int unsigned PIN_TX = 6;
	localparam int unsigned PIN_CS = 7;
	localparam int unsigned PIN_TOG = 8;
	localparam int unsigned NUM_PINS = 9;
	localparam logic [8:0] SYNC_RST = 9'h0d0;

	typedef enum logic [5:0] {
		SMC_RESET = 6'h01,
		SMC_NREQ = 6'h02,
		SMC_NORMAL = 6'h04,
		SMC_STANDBY = 6'h08,
		SMC_SLEEP = 6'h10,
		SMC_EMERG = 6'h20
	} smc_state_t;

endpackage : smc_pkg

// >>> hdl/smc_spi_if.sv
`timescale 1ns/1ps
interface smc_spi_if;
	logic [smc_pkg::CMD_W-1:0] word;
	logic tog;
	modport rx (output word, output tog);
	modport core (input word, input tog);
endinterface : smc_spi_if

// >>> hdl/smc_spi_rx.sv
`timescale 1ns/1ps
module smc_spi_rx (
	// Link clock and reset.
	input wire logic spi_sclk_i,
	input wire logic rst_n_i,
	// Serial pins.
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	// Received frame towards the core.
	smc_spi_if.rx spi
);
	import smc_pkg::*;

	typedef struct packed {
		logic [CMD_W-1:0] sh;
		logic [CNT_W-1:0] cnt;
		logic [CMD_W-1:0] word;
		logic tog;
	} smc_rx_t;

	smc_rx_t r;
	smc_rx_t n;

	// Shifts MSB first; the word is held until the next frame completes.
	always_comb begin
		n = r;
		if (!spi_cs_n_i) begin
			n.sh = {r.sh[CMD_W-2:0], spi_mosi_i};
			n.cnt = r.cnt + 4'h1;
			if (r.cnt == CNT_LAST) begin
				n.word = {r.sh[CMD_W-2:0], spi_mosi_i};
				n.tog = ~r.tog;
			end
		end
	end

	always_ff @(posedge spi_sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign spi.word = r.word;
	assign spi.tog = r.tog;

endmodule : smc_spi_rx

// >>> hdl/smc_mode_controller.sv
`timescale 1ns/1ps
// Behaviour
// (RULE1) Transceiver mode follows host-written control register.
// (RULE2) Full duplex: transmit, receive, full failure detection.
// (RULE3) Listen-only: no transmit, receive echoes local transmit.
// (RULE4) Bus stand-by: paths off, wake sensing, termination battery.
// (RULE5) Bus stand-by: bias CANL, pull currents off.
// (RULE6) Transceiver mode changes by command or fail-safe only.
// (RULE7) Bus dominant in low power wakes and records.
// (RULE8) Wake-up needs dominant level for filter time.
// (RULE9) Power-up leads to normal-request, bus stand-by.
// (RULE10) Aux under-voltage forces bus stand-by.
// (RULE11) Reset lasts minimum time, then normal-request.
// (RULE12) Main under-voltage enters reset, holds until recovery.
// (RULE13) Normal-request: main on, aux and battery off.
// (RULE14) No command within timeout sends chip to sleep.
// (RULE15) Timing word first, then watchdog and other commands.
// (RULE16) Unconfigured: watchdog, aux, transmitter all off.
// (RULE17) Normal: main and aux on, battery per command.
// (RULE18) Normal exits by command, watchdog or under-voltage.
// (RULE19) Stand-by: main on, aux off, watchdog active.
// (RULE20) Stand-by exits by command, fault or reset pin.
// (RULE21) Sleep: regulators off, battery off or cyclic.
// (RULE22) Unconfigured normal-request ignores commands except emergency.
// (RULE23) Aux off leaves transceiver in bus stand-by.
// (RULE24) Trigger outside enable window causes reset.
// (RULE25) Emergency left only on battery loss.
// (RULE26) Commands take effect at chip-select deassertion.
module smc_mode_controller #(
	parameter int unsigned RESET_MIN_CYC = smc_pkg::RESET_MIN_US * smc_pkg::CLK_MHZ,
	parameter int unsigned UV_HOLD_CYC = smc_pkg::UV_HOLD_MS * smc_pkg::US_PER_MS
		* smc_pkg::CLK_MHZ,
	parameter int unsigned NREQ_TO_CYC = smc_pkg::NREQ_TO_MS * smc_pkg::US_PER_MS
		* smc_pkg::CLK_MHZ,
	parameter int unsigned CYC_PER_MS = smc_pkg::US_PER_MS * smc_pkg::CLK_MHZ,
	parameter int unsigned WAKE_FILT_CYC = smc_pkg::WAKE_FILT_US * smc_pkg::CLK_MHZ,
	parameter int unsigned CYCLIC_PERIOD_CYC = smc_pkg::CYCLIC_PERIOD_MS
		* smc_pkg::US_PER_MS * smc_pkg::CLK_MHZ,
	parameter int unsigned CYCLIC_ON_CYC = smc_pkg::CYCLIC_ON_US * smc_pkg::CLK_MHZ
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Serial command link.
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	// Supply monitors.
	input wire logic main_uv_i,
	input wire logic aux_uv_i,
	input wire logic bat_loss_i,
	// Bus sensing and local transmit data.
	input wire logic canh_dom_i,
	input wire logic canl_dom_i,
	input wire logic can_txd_i,
	// Transceiver controls.
	output logic can_rxd_o,
	output logic can_tx_en_o,
	output logic can_rx_en_o,
	output logic fail_det_full_o,
	output logic fail_det_partial_o,
	output logic low_term_batt_o,
	output logic canl_pullup_en_o,
	output logic canh_pulldown_en_o,
	output logic wake_sense_en_o,
	// Reset pin, open drain.
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_n_o,
	// Supply switches.
	output logic main_reg_en_o,
	output logic aux_reg_en_o,
	output logic batt_sw_en_o,
	// Status.
	output smc_pkg::smc_state_t mode_o,
	output logic [1:0] can_mode_o,
	output logic [1:0] wakeup_status_o,
	output logic int_n_o,
	output logic wdog_active_o,
	output logic main_uv_fault_o
);
	import smc_pkg::*;

	if (RESET_MIN_CYC < 1 || UV_HOLD_CYC < 1 || NREQ_TO_CYC < 1 || CYC_PER_MS < 2
		|| WAKE_FILT_CYC < 1 || WAKE_FILT_CYC > 65535 || CYCLIC_ON_CYC < 1
		|| CYCLIC_PERIOD_CYC <= CYCLIC_ON_CYC || CYC_PER_MS > 20000000) begin : g_chk
		$error("smc_mode_controller: timing parameter out of range");
	end

	typedef struct packed {
		logic [NUM_PINS-1:0] s1;
		logic [NUM_PINS-1:0] s2;
		logic [NUM_PINS-1:0] s3;
		logic [NUM_PINS-1:0] f;
		smc_state_t state;
		logic [31:0] timer;
		logic [31:0] uv_tmr;
		logic [31:0] wd_cnt;
		logic [31:0] cyc_cnt;
		logic [15:0] wake_cnt;
		logic cs_prev;
		logic tog_seen;
		logic pend;
		logic spi_seen;
		logic timing_cfg;
		logic [2:0] wd_sel;
		logic batt_on;
		logic batt_cyclic;
		logic [1:0] can_mode;
		logic [1:0] wake_stat;
		logic rx_dom;
		logic main_en;
		logic aux_en;
		logic batt_en;
		logic tx_en;
		logic rx_en;
		logic fdf;
		logic fdp;
		logic lterm;
		logic pull_en;
		logic wsense;
		logic rst_drive;
	} smc_core_t;

	localparam smc_core_t CORE_RST = '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST,
		f: SYNC_RST, state: SMC_RESET, cs_prev: 1'b1, main_en: 1'b1, fdp: 1'b1,
		lterm: 1'b1, wsense: 1'b1, rst_drive: 1'b1, default: '0};

	function automatic logic [2:0] cmd_addr(input logic [CMD_W-1:0] w);
		cmd_addr = w[CMD_ADDR_HI:CMD_ADDR_LO];
	endfunction : cmd_addr

	function automatic logic [31:0] wd_period(input logic [2:0] sel);
		wd_period = 32'(WD_MS_TAB[sel]) * 32'(CYC_PER_MS);
	endfunction : wd_period

	smc_spi_if u_if ();

	smc_spi_rx u_rx (
		.spi_sclk_i(spi_sclk_i),
		.rst_n_i(rst_n_i),
		.spi_cs_n_i(spi_cs_n_i),
		.spi_mosi_i(spi_mosi_i),
		.spi(u_if)
	);

	smc_core_t r;
	smc_core_t n;
	logic [NUM_PINS-1:0] pins;
	logic main_uv, aux_uv, bat_loss, bus_dom, tx_dom, rst_low;
	logic tog_chg, cs_rise, apply, low_pow, wake_evt, wd_act, wd_trig, wd_bad, wd_to;
	logic force_stby;
	logic [2:0] addr;
	logic [CMD_W-1:0] cmd;
	logic [31:0] period;

	assign pins = {u_if.tog, spi_cs_n_i, can_txd_i, bat_loss_i, rst_pin_i, canl_dom_i,
		canh_dom_i, aux_uv_i, main_uv_i};
	assign main_uv = r.f[PIN_MAIN_UV];
	assign aux_uv = r.f[PIN_AUX_UV];
	assign bat_loss = r.f[PIN_BAT_LOSS];
	assign bus_dom = r.f[PIN_CANH] | r.f[PIN_CANL];
	assign tx_dom = ~r.f[PIN_TX];
	assign rst_low = ~r.f[PIN_RST] & ~r.rst_drive;
	assign tog_chg = r.f[PIN_TOG] ^ r.tog_seen;
	assign cs_rise = r.f[PIN_CS] & ~r.cs_prev;
	assign apply = cs_rise & (r.pend | tog_chg); // RULE26
	assign cmd = u_if.word;
	assign addr = cmd_addr(cmd);
	assign low_pow = r.can_mode == CAN_STBY;
	assign wake_evt = low_pow & bus_dom & r.wake_cnt == 16'(WAKE_FILT_CYC - 1); // RULE8
	assign wd_act = r.timing_cfg & (r.state == SMC_NORMAL | r.state == SMC_STANDBY);
	assign period = wd_period(r.wd_sel);
	assign wd_trig = apply & addr == ADDR_WDOG & wd_act;
	assign wd_bad = wd_trig & r.wd_cnt < (period >> 1); // RULE24
	assign wd_to = wd_act & r.wd_cnt >= period - 32'h1;
	assign force_stby = n.state != SMC_NORMAL | aux_uv;

	always_comb begin
		n = r;
		n.s1 = pins;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.f = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.f);
		n.cs_prev = r.f[PIN_CS];
		n.tog_seen = r.f[PIN_TOG];
		n.pend = (r.pend | tog_chg) & ~apply;
		if (r.timer != 32'hffffffff) begin
			n.timer = r.timer + 32'h1;
		end
		if (low_pow & bus_dom & r.state != SMC_RESET & r.state != SMC_EMERG) begin
			if (r.wake_cnt != 16'(WAKE_FILT_CYC)) begin
				n.wake_cnt = r.wake_cnt + 16'h1; // RULE8
			end
		end else begin
			n.wake_cnt = '0;
		end
		n.wake_stat = r.wake_stat & ~((apply & addr == ADDR_WAKE_CLR)
			? cmd[WAKE_CLR_HI:0] : 2'h0);
		if (wake_evt) begin
			n.wake_stat = n.wake_stat | {r.f[PIN_CANL], r.f[PIN_CANH]}; // RULE7
		end
		if (!wd_act || wd_trig) begin
			n.wd_cnt = '0;
		end else begin
			n.wd_cnt = r.wd_cnt + 32'h1;
		end
		if (r.state == SMC_SLEEP && r.cyc_cnt < 32'(CYCLIC_PERIOD_CYC - 1)) begin
			n.cyc_cnt = r.cyc_cnt + 32'h1;
		end else begin
			n.cyc_cnt = '0;
		end
		case (r.state)
			SMC_RESET: begin
				if (main_uv) begin
					if (r.uv_tmr != 32'hffffffff) begin
						n.uv_tmr = r.uv_tmr + 32'h1; // RULE12
					end
				end else begin
					n.uv_tmr = '0;
				end
				if (r.timer >= 32'(RESET_MIN_CYC - 1) && !main_uv) begin
					n.state = SMC_NREQ; // RULE11 RULE9
				end
			end
			SMC_NREQ: begin
				if (apply) begin
					n.spi_seen = 1'b1;
					if (addr == ADDR_TIMING) begin
						n.timing_cfg = 1'b1; // RULE15
						n.wd_sel = cmd[WD_SEL_HI:0];
						n.state = SMC_NORMAL; // RULE17
					end else if (addr == ADDR_MODE && cmd[MODE_REQ_HI:0] == REQ_EMERG) begin
						n.state = SMC_EMERG; // RULE22
					end
				end else if (!r.spi_seen && r.timer >= 32'(NREQ_TO_CYC - 1)) begin
					n.state = SMC_SLEEP; // RULE14
				end
				if (main_uv) begin
					n.state = SMC_RESET; // RULE12
				end
			end
			SMC_NORMAL, SMC_STANDBY: begin
				if (apply) begin
					case (addr)
						ADDR_TIMING: begin
							n.wd_sel = cmd[WD_SEL_HI:0];
						end
						ADDR_CAN: begin
							if (cmd[CAN_MODE_HI:0] != 2'h3) begin
								n.can_mode = cmd[CAN_MODE_HI:0]; // RULE1 RULE6
							end
						end
						ADDR_MODE: begin
							n.batt_on = cmd[MODE_BATT_BIT];
							n.batt_cyclic = cmd[MODE_CYCLIC_BIT];
							case (cmd[MODE_REQ_HI:0])
								REQ_NORMAL: n.state = SMC_NORMAL;
								REQ_STANDBY: n.state = SMC_STANDBY;
								REQ_SLEEP: n.state = SMC_SLEEP;
								REQ_EMERG: n.state = SMC_EMERG;
								default: n.state = r.state;
							endcase
						end
						default: n.state = r.state;
					endcase
				end
				if (wd_to || wd_bad || main_uv) begin
					n.state = SMC_RESET; // RULE18 RULE20 RULE24
				end
				if (r.state == SMC_STANDBY && rst_low) begin
					n.state = SMC_RESET; // RULE20
				end
			end
			SMC_SLEEP: begin
				if (wake_evt) begin
					n.state = SMC_NREQ; // RULE7
				end
			end
			SMC_EMERG: begin
				if (bat_loss) begin
					n.state = SMC_RESET; // RULE25
				end
			end
			default: n.state = SMC_RESET;
		endcase
		if (n.state != r.state) begin
			n.timer = '0;
			if (n.state == SMC_RESET || n.state == SMC_NREQ) begin
				n.uv_tmr = '0;
				n.spi_seen = 1'b0;
				n.timing_cfg = 1'b0; // RULE13
				n.wd_sel = '0;
				n.batt_on = 1'b0;
				n.batt_cyclic = 1'b0;
			end
		end
		if (n.state != SMC_NORMAL || aux_uv) begin
			n.can_mode = CAN_STBY; // RULE10 RULE23
		end
		n.main_en = n.state == SMC_RESET | n.state == SMC_NREQ | n.state == SMC_NORMAL
			| n.state == SMC_STANDBY; // RULE13 RULE19 RULE21
		n.aux_en = n.state == SMC_NORMAL & n.timing_cfg; // RULE16 RULE17 RULE19
		case (n.state)
			SMC_NORMAL: n.batt_en = n.batt_on; // RULE17
			SMC_STANDBY: n.batt_en = n.batt_on; // RULE19
			SMC_SLEEP: n.batt_en = n.batt_cyclic & n.cyc_cnt < 32'(CYCLIC_ON_CYC); // RULE21
			default: n.batt_en = 1'b0;
		endcase
		n.tx_en = n.can_mode == CAN_FD & n.timing_cfg; // RULE2 RULE16
		n.rx_en = n.can_mode != CAN_STBY; // RULE2 RULE3
		n.fdf = n.can_mode != CAN_STBY; // RULE2
		n.fdp = n.can_mode == CAN_STBY; // RULE4
		n.lterm = n.can_mode == CAN_STBY; // RULE4 RULE5
		n.pull_en = n.can_mode != CAN_STBY; // RULE5
		n.wsense = n.can_mode == CAN_STBY; // RULE4
		case (n.can_mode)
			CAN_FD: n.rx_dom = bus_dom;
			CAN_LO: n.rx_dom = bus_dom | tx_dom; // RULE3
			default: n.rx_dom = 1'b0;
		endcase
		n.rst_drive = n.state == SMC_RESET; // RULE11
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= CORE_RST;
		end else begin
			r <= n;
		end
	end

	assign can_rxd_o = ~r.rx_dom;
	assign can_tx_en_o = r.tx_en;
	assign can_rx_en_o = r.rx_en;
	assign fail_det_full_o = r.fdf;
	assign fail_det_partial_o = r.fdp;
	assign low_term_batt_o = r.lterm;
	assign canl_pullup_en_o = r.pull_en;
	assign canh_pulldown_en_o = r.pull_en;
	assign wake_sense_en_o = r.wsense;
	assign rst_pin_o = 1'b0;
	assign rst_pin_oe_n_o = ~r.rst_drive;
	assign main_reg_en_o = r.main_en;
	assign aux_reg_en_o = r.aux_en;
	assign batt_sw_en_o = r.batt_en;
	assign mode_o = r.state;
	assign can_mode_o = r.can_mode;
	assign wakeup_status_o = r.wake_stat;
	assign int_n_o = ~(|r.wake_stat & r.state != SMC_SLEEP);
	assign wdog_active_o = wd_act;
	assign main_uv_fault_o = r.state == SMC_RESET & r.uv_tmr >= 32'(UV_HOLD_CYC);

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_normal_then_standby;
		r.state == SMC_NORMAL ##1 r.state == SMC_STANDBY;
	endsequence

	a_fd_paths_on: assert property (r.can_mode == CAN_FD |-> r.tx_en == r.timing_cfg // RULE2
		&& r.rx_en && r.fdf && !r.fdp) else $error("full duplex paths wrong");
	a_lo_rx_echo: assert property (n.can_mode == CAN_LO |=> !r.tx_en // RULE3
		&& r.rx_dom == ($past(bus_dom) || $past(tx_dom))) else $error("listen-only echo wrong");
	a_stby_bias_set: assert property (r.can_mode == CAN_STBY |-> r.lterm && r.wsense // RULE5
		&& !r.pull_en && !r.tx_en && !r.rx_en && r.fdp) else $error("bus stand-by bias wrong");
	a_aux_uv_force: assert property (aux_uv |=> r.can_mode == CAN_STBY) // RULE10
		else $error("aux under-voltage did not force stand-by");
	a_can_mode_cause: assert property ($changed(r.can_mode) |-> $past(apply) // RULE6
		|| $past(force_stby)) else $error("transceiver mode changed without cause");
	a_reset_min_len: assert property ($fell(r.state == SMC_RESET) |-> // RULE11
		$past(r.timer) >= 32'(RESET_MIN_CYC - 1) && r.state == SMC_NREQ)
		else $error("reset left too early");
	a_nreq_power_set: assert property (r.state == SMC_NREQ |-> r.main_en && !r.aux_en // RULE13
		&& !r.batt_en && r.can_mode == CAN_STBY) else $error("normal-request supplies wrong");
	a_nreq_to_sleep: assert property (r.state == SMC_NREQ && !r.spi_seen && !apply // RULE14
		&& !main_uv && r.timer == 32'(NREQ_TO_CYC - 1) |=> r.state == SMC_SLEEP)
		else $error("normal-request timeout missed");
	a_timing_first: assert property (r.state == SMC_NREQ && apply && addr == ADDR_TIMING // RULE15
		&& !main_uv |=> r.state == SMC_NORMAL && wdog_active_o && r.aux_en)
		else $error("timing word did not start normal mode");
	a_uncfg_off: assert property (!r.timing_cfg |-> !wd_act && !r.aux_en && !r.tx_en) // RULE16
		else $error("unconfigured chip enabled watchdog or supply");
	a_nreq_ignore: assert property (r.state == SMC_NREQ && apply && addr == ADDR_MODE // RULE22
		&& cmd[MODE_REQ_HI:0] == REQ_STANDBY |=> r.state != SMC_STANDBY)
		else $error("command accepted before timing word");
	a_main_uv_reset: assert property (main_uv && (r.state == SMC_NORMAL // RULE12
		|| r.state == SMC_STANDBY || r.state == SMC_NREQ) |=> r.state == SMC_RESET ##1
		r.rst_drive) else $error("main under-voltage did not reset");
	a_wake_sleep_nreq: assert property (wake_evt && r.state == SMC_SLEEP |=> // RULE7
		r.state == SMC_NREQ && r.wake_stat != 2'h0) else $error("sleep wake-up missed");
	a_wake_filtered: assert property (wake_evt |-> $past(bus_dom) // RULE8
		&& r.wake_cnt == 16'(WAKE_FILT_CYC - 1)) else $error("wake-up not filtered");
	a_wd_bad_reset: assert property (wd_bad |=> r.state == SMC_RESET) // RULE24
		else $error("early trigger did not reset");
	a_standby_supply: assert property (r.state == SMC_STANDBY |-> r.main_en && !r.aux_en // RULE19
		&& (wd_act == r.timing_cfg)) else $error("stand-by supplies wrong");
	a_sleep_supply: assert property (r.state == SMC_SLEEP |-> !r.main_en && !r.aux_en // RULE21
		&& (r.batt_cyclic || !r.batt_en)) else $error("sleep supplies wrong");
	a_emerg_hold: assert property (r.state == SMC_EMERG && !bat_loss |=> // RULE25
		r.state == SMC_EMERG) else $error("emergency left without battery loss");
	a_cmd_at_cs: assert property (s_normal_then_standby |-> $past(apply) || $past(rst_low)) // RULE26
		else $error("mode change outside chip-select release");

endmodule : smc_mode_controller

// >>> sim/smc_host_model.sv
`timescale 1ns/1ps
module smc_host_model (
	// Serial command pins.
	output logic spi_sclk_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o
);
	initial begin
		spi_sclk_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_mosi_o = 1'b0;
	end

	// Sends one word MSB first; the clock stands low outside frames.
	// Data idles at the inverse of the last bit, so it is never mistaken for a held value.
	task automatic send(input logic [15:0] word);
		spi_cs_n_o = 1'b0;
		#17;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi_o = word[i];
			#40 spi_sclk_o = 1'b1;
			#40 spi_sclk_o = 1'b0;
		end
		#40 spi_cs_n_o = 1'b1;
		spi_mosi_o = ~word[0];
		#100;
	endtask : send
endmodule : smc_host_model

// >>> sim/tb_smc_mode_controller.sv
`timescale 1ns/1ps
module tb_smc_mode_controller;
	import smc_pkg::*;
	logic ref_clk_i, rst_n_i, spi_sclk_i, spi_cs_n_i, spi_mosi_i, main_uv_i, aux_uv_i;
	logic bat_loss_i, canh_dom_i, canl_dom_i, can_txd_i, can_rxd_o, can_tx_en_o, can_rx_en_o;
	logic fail_det_full_o, fail_det_partial_o, low_term_batt_o, canl_pullup_en_o;
	logic canh_pulldown_en_o, wake_sense_en_o, rst_pin_o, rst_pin_oe_n_o, main_reg_en_o;
	logic aux_reg_en_o, batt_sw_en_o, int_n_o, wdog_active_o, main_uv_fault_o, rst_ext_n, b;
	logic [1:0] can_mode_o, wakeup_status_o;
	smc_state_t mode_o;
	smc_state_t exp_q[$];
	int fails = 0;
	int cmp_count = 0;
	int seed = 57823;
	bit armed = 1'b0;
	// The reset pin is open drain with a pull-up.
	wire logic rst_pin = rst_ext_n & (rst_pin_oe_n_o | rst_pin_o);
	wire logic [7:0] xcvr = {can_tx_en_o, can_rx_en_o, fail_det_full_o, fail_det_partial_o,
		low_term_batt_o, canl_pullup_en_o, canh_pulldown_en_o, wake_sense_en_o};

	smc_host_model i_host (
		.spi_sclk_o(spi_sclk_i),
		.spi_cs_n_o(spi_cs_n_i),
		.spi_mosi_o(spi_mosi_i)
	);
	smc_mode_controller #(.RESET_MIN_CYC(20), .UV_HOLD_CYC(50), .NREQ_TO_CYC(600),
		.CYC_PER_MS(100), .WAKE_FILT_CYC(8)
	) i_smc_mode_controller (.rst_pin_i(rst_pin), .*);

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	task automatic conclude;
		$display("counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s: got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick

	task automatic go(input smc_state_t m);
		exp_q.push_back(m);
	endtask : go

	task automatic wait_mode(input smc_state_t m);
		int n = 0;
		while (mode_o !== m && n < 3000) begin
			@(posedge ref_clk_i);
			n++;
		end
		#1;
		chk(mode_o, m, "mode reached");
	endtask : wait_mode

	function automatic logic [15:0] cmd(input logic [2:0] a, input logic [12:0] d);
		return {a, d};
	endfunction : cmd

	// Every mode change after arming is matched against the oldest expected mode.
	initial forever begin
		@(mode_o);
		if (armed) begin
			if (exp_q.size() == 0) chk(mode_o, 8'hff, "unexpected mode change");
			else chk(mode_o, exp_q.pop_front(), "mode order");
		end
	end

	initial begin
		#200000;
		fails++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end

	initial begin
		{rst_n_i, main_uv_i, aux_uv_i, bat_loss_i, canh_dom_i, canl_dom_i} = 6'h0;
		can_txd_i = 1'b1;
		rst_ext_n = 1'b1;
		b = 1'b0;
		tick(20);
		chk(mode_o, SMC_RESET, "reset mode");
		chk({main_reg_en_o, aux_reg_en_o, batt_sw_en_o, low_term_batt_o, can_mode_o}, 8'h24, "rst");
		armed = 1'b1;
		rst_n_i = 1'b1;
		go(SMC_NREQ);
		wait_mode(SMC_NREQ);
		chk({main_reg_en_o, aux_reg_en_o, batt_sw_en_o, wdog_active_o}, 8'h8, "nreq");
		i_host.send(cmd(ADDR_CAN, 13'(CAN_FD)));
		chk({can_mode_o, can_tx_en_o}, 8'h0, "early cmd");
		i_host.send(cmd(ADDR_MODE, 13'(REQ_STANDBY)));
		chk(mode_o, SMC_NREQ, "early mode");
		go(SMC_NORMAL);
		i_host.send(cmd(ADDR_TIMING, 13'h7));
		wait_mode(SMC_NORMAL);
		chk({main_reg_en_o, aux_reg_en_o, wdog_active_o}, 8'h7, "normal");
		$display("test power-up done");
		can_txd_i = 1'b0;
		for (int k = 1; k <= 2; k++) begin
			i_host.send(cmd(ADDR_CAN, 13'(k)));
			b = (k == 1);
			chk(xcvr & 8'hfe, b ? 8'he6 : 8'h66, "xcvr");
			chk({can_mode_o, can_rxd_o}, {2'(k), b}, "rx echo");
		end
		i_host.send(cmd(ADDR_CAN, 13'(CAN_STBY)));
		chk(xcvr, 8'h19, "bus standby");
		canh_dom_i = 1'b1;
		tick(30);
		canh_dom_i = 1'b0;
		tick(5);
		chk({wakeup_status_o, int_n_o}, 8'h2, "wake flag");
		i_host.send(cmd(ADDR_WAKE_CLR, 13'h3));
		chk({wakeup_status_o, int_n_o}, 8'h1, "wake clear");
		i_host.send(cmd(ADDR_CAN, 13'(CAN_FD)));
		aux_uv_i = 1'b1;
		tick(10);
		chk({can_mode_o, can_tx_en_o}, 8'h0, "aux uv");
		aux_uv_i = 1'b0;
		tick(10);
		chk({can_mode_o, can_tx_en_o}, 8'h0, "aux back");
		$display("test transceiver done");
		b = 1'($random(seed));
		go(SMC_STANDBY);
		i_host.send(cmd(ADDR_MODE, {9'h0, b, REQ_STANDBY}));
		wait_mode(SMC_STANDBY);
		chk({main_reg_en_o, aux_reg_en_o, batt_sw_en_o, wdog_active_o}, {2'b10, b, 1'b1}, "stby");
		go(SMC_RESET);
		go(SMC_NREQ);
		rst_ext_n = 1'b0;
		tick(5);
		rst_ext_n = 1'b1;
		wait_mode(SMC_NREQ);
		$display("test standby done");
		go(SMC_SLEEP);
		wait_mode(SMC_SLEEP);
		chk({main_reg_en_o, aux_reg_en_o}, 8'h0, "sleep");
		canl_dom_i = 1'b1;
		tick(4);
		canl_dom_i = 1'b0;
		tick(20);
		chk({mode_o, wakeup_status_o}, {SMC_SLEEP, 2'b00}, "glitch");
		canl_dom_i = 1'b1;
		go(SMC_NREQ);
		wait_mode(SMC_NREQ);
		canl_dom_i = 1'b0;
		chk(wakeup_status_o, 8'h2, "sleep wake");
		$display("test sleep done");
		go(SMC_NORMAL);
		i_host.send(cmd(ADDR_TIMING, 13'h1));
		wait_mode(SMC_NORMAL);
		tick(250);
		i_host.send(cmd(ADDR_WDOG, 13'h0));
		chk(mode_o, SMC_NORMAL, "good trigger");
		go(SMC_RESET);
		go(SMC_NREQ);
		i_host.send(cmd(ADDR_WDOG, 13'h0));
		wait_mode(SMC_NREQ);
		main_uv_i = 1'b1;
		go(SMC_RESET);
		wait_mode(SMC_RESET);
		tick(70);
		chk({mode_o, main_uv_fault_o}, {SMC_RESET, 1'b1}, "uv hold");
		main_uv_i = 1'b0;
		go(SMC_NREQ);
		wait_mode(SMC_NREQ);
		go(SMC_EMERG);
		i_host.send(cmd(ADDR_MODE, 13'(REQ_EMERG)));
		wait_mode(SMC_EMERG);
		tick(100);
		bat_loss_i = 1'b1;
		go(SMC_RESET);
		go(SMC_NREQ);
		tick(10);
		bat_loss_i = 1'b0;
		wait_mode(SMC_NREQ);
		chk(8'(exp_q.size()), 8'h0, "pending modes");
		$display("test faults done");
		conclude();
	end
endmodule : tb_smc_mode_controller
